// *** rtl/card_socket_irq_status.v ***
// Per-socket interrupt routing and card status change logic
// Overview of operation
// - Card IRQ select routes card request; 0000 and reserved codes off
// - IRQ 12 may drive an LED, IRQ 15 may carry ring indicate
// - Redirect bit 0: management interrupt on the management IRQ select
// - Redirect bit 1: management interrupt on the dedicated output
// - Interface mode bit: 0 memory card, 1 I/O card
// - Reset control 0: reset active, high normal, low ATA
// - Reset control 1: reset inactive, low normal, high ATA
// - Socket output enable 0 floats the reset output
// - Ring enable makes battery-dead pin a ring indicate input
// - Ring enable ignored in memory card mode
// - Status change register names pending source; upper nibble zero
// - Memory mode: battery-dead flag on falling edge
// - I/O mode: battery-dead flag on either edge
// - I/O mode: battery-dead detection ignores ring enable
// - Any read of status change register clears all flags
// - Memory mode: battery warning flag on falling edge
// - Ready flag on ready pin change; reads zero in I/O mode
// - Card detect flag on change of either detect pin
// - Management interrupt when an enabled flag is set, except battery warning in I/O mode
`timescale 1ns/1ps
`include "card_socket_map.vh"
module card_socket_irq_status (
  input wire clk, // 100 MHz clock
  input wire arst_n, // Asynchronous reset, active low
  input wire [7:0] addr, // Register address
  input wire [7:0] wdata, // Write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  output reg [7:0] rdata_r, // Read data, cycle after rd
  input wire card_ready_irq_pin, // Card ready / interrupt request
  input wire battery_dead_status_pin, // Battery dead / status change
  input wire battery_warning_pin, // Battery warning
  input wire card_detect_a_n, // Card detect one, active low
  input wire card_detect_b_n, // Card detect two, active low
  output reg [`IRQ_W-1:0] host_irq_r, // Host IRQ lines, active high
  output reg host_mgmt_interrupt_out_r, // Dedicated management interrupt
  output reg card_reset_out_r, // Socket reset level
  output reg card_reset_oe_r, // Socket reset drive enable
  output reg io_mode_r, // High while socket in I/O card mode
  output reg ring_indicate_r // Ring indicate level, active high
);
  ////////////////////////////////////////////////////////////////////////
  // Reset release
  reg rst_a_r;
  reg rst_n_r;

  // Two-flop release of the asynchronous reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire rdy_s;
  wire bvd_s;
  wire bwarn_s;
  wire cda_s;
  wire cdb_s;

  pin_sync #(.RESET_VAL(1'b1)) u_rdy (
    .clk(clk), .rst_n(rst_n_r), .pin(card_ready_irq_pin), .level_r(rdy_s));
  pin_sync #(.RESET_VAL(1'b1)) u_bvd (
    .clk(clk), .rst_n(rst_n_r), .pin(battery_dead_status_pin),
    .level_r(bvd_s));
  pin_sync #(.RESET_VAL(1'b1)) u_bwarn (
    .clk(clk), .rst_n(rst_n_r), .pin(battery_warning_pin),
    .level_r(bwarn_s));
  pin_sync #(.RESET_VAL(1'b1)) u_cda (
    .clk(clk), .rst_n(rst_n_r), .pin(card_detect_a_n), .level_r(cda_s));
  pin_sync #(.RESET_VAL(1'b1)) u_cdb (
    .clk(clk), .rst_n(rst_n_r), .pin(card_detect_b_n), .level_r(cdb_s));

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] igc_r; // Interrupt and general control
  reg [7:0] mic_r; // Management interrupt configuration
  reg [7:0] sock_r; // Socket control (output enable, ATA, pin options)
  reg [3:0] csc_r; // Status change flags
  reg [3:0] csc_nxt;
  reg rdy_d_r;
  reg bvd_d_r;
  reg bwarn_d_r;
  reg cda_d_r;
  reg cdb_d_r;

  wire io_mode = igc_r[`IGC_IOMODE];
  wire csc_rd = rd && (addr == `REG_CSC);

  // Register writes
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      igc_r <= `IGC_RESET;
      mic_r <= `MIC_RESET;
      sock_r <= `SOCK_CTL_RESET;
    end else if (wr) begin
      if (addr == `REG_IGC) begin
        igc_r <= wdata;
      end
      if (addr == `REG_MIC) begin
        mic_r <= wdata;
      end
      if (addr == `REG_SOCK_CTL) begin
        sock_r <= {3'h0, wdata[4:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status change detection
  wire bvd_fall = bvd_d_r && !bvd_s;
  wire bvd_edge = bvd_d_r ^ bvd_s;
  wire bwarn_fall = bwarn_d_r && !bwarn_s;
  wire rdy_edge = rdy_d_r ^ rdy_s;
  wire cd_edge = (cda_d_r ^ cda_s) | (cdb_d_r ^ cdb_s);
  wire bvd_ev = io_mode ? bvd_edge : bvd_fall;

  // Flags: read clears, but a new event in that cycle still sets
  always @* begin
    csc_nxt = csc_r;
    if (csc_rd) begin
      csc_nxt = 4'h0;
    end
    if (bvd_ev) begin
      csc_nxt[`CSC_BVD] = 1'b1;
    end
    if (bwarn_fall && !io_mode) begin
      csc_nxt[`CSC_BWARN] = 1'b1;
    end
    if (rdy_edge && !io_mode) begin
      csc_nxt[`CSC_RDY] = 1'b1;
    end
    if (io_mode) begin
      csc_nxt[`CSC_RDY] = 1'b0;
    end
    if (cd_edge) begin
      csc_nxt[`CSC_CD] = 1'b1;
    end
  end

  // Edge history and flag storage
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      csc_r <= 4'h0;
      rdy_d_r <= 1'b1;
      bvd_d_r <= 1'b1;
      bwarn_d_r <= 1'b1;
      cda_d_r <= 1'b1;
      cdb_d_r <= 1'b1;
    end else begin
      csc_r <= csc_nxt;
      rdy_d_r <= rdy_s;
      bvd_d_r <= bvd_s;
      bwarn_d_r <= bwarn_s;
      cda_d_r <= cda_s;
      cdb_d_r <= cdb_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt routing
  wire [3:0] en_mask = {mic_r[3:2], mic_r[1] & ~io_mode, mic_r[0]};
  wire mgmt_req = |(csc_r & en_mask);
  wire redir = igc_r[`IGC_REDIR];
  wire card_req = !rdy_s && io_mode; // Card asserts request low
  // Ring indicate only in I/O mode with ring enable set
  wire ring = io_mode && igc_r[`IGC_RIEN] && !bvd_s;
  wire [`IRQ_W-1:0] card_irq;
  wire [`IRQ_W-1:0] mgmt_irq;
  reg [`IRQ_W-1:0] irq_nxt;

  irq_decode u_card_dec (
    .sel(igc_r[`IGC_SEL_MSB:`IGC_SEL_LSB]), .req(card_req),
    .irq(card_irq));
  irq_decode u_mgmt_dec (
    .sel(mic_r[`MIC_SEL_MSB:`MIC_SEL_LSB]), .req(mgmt_req && !redir),
    .irq(mgmt_irq));

  // Merge card and management lines; apply alternate pin functions
  always @* begin
    irq_nxt = card_irq | mgmt_irq;
    if (sock_r[`SOCK_LED]) begin
      irq_nxt[`IRQ_LED] = sock_r[`SOCK_LEDON];
    end
    if (sock_r[`SOCK_RIOUT]) begin
      irq_nxt[`IRQ_RING] = ring;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and read port
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      host_irq_r <= {`IRQ_W{1'b0}};
      host_mgmt_interrupt_out_r <= 1'b0;
      card_reset_out_r <= 1'b0;
      card_reset_oe_r <= 1'b0;
      io_mode_r <= 1'b0;
      ring_indicate_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      host_irq_r <= irq_nxt;
      host_mgmt_interrupt_out_r <= mgmt_req && redir;
      // Active level: high normal, low ATA; inactive is its inverse
      card_reset_out_r <= igc_r[`IGC_RSTCTL] ~^ sock_r[`SOCK_ATA];
      card_reset_oe_r <= sock_r[`SOCK_OE];
      io_mode_r <= io_mode;
      ring_indicate_r <= ring;
      rdata_r <= 8'h00;
      if (rd) begin
        case (addr)
          `REG_IGC: rdata_r <= igc_r;
          `REG_CSC: rdata_r <= {4'h0, csc_r};
          `REG_MIC: rdata_r <= mic_r;
          `REG_SOCK_CTL: rdata_r <= sock_r;
          `REG_PIN_STAT: rdata_r <= {3'h0, cdb_s, cda_s, bwarn_s, bvd_s, rdy_s};
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end
  // Each instance holds private registers; one per socket
endmodule // card_socket_irq_status

// *** rtl/card_socket_map.vh ***
// Register offsets, field positions and reset values of the socket block
`ifndef CARD_SOCKET_MAP_VH
`define CARD_SOCKET_MAP_VH
`define REG_IGC 8'h03
`define REG_CSC 8'h04
`define REG_MIC 8'h05
`define REG_SOCK_CTL 8'h08
`define REG_PIN_STAT 8'h09
`define IGC_RESET 8'h00
`define MIC_RESET 8'h00
`define SOCK_CTL_RESET 8'h00
`define IGC_SEL_LSB 0
`define IGC_SEL_MSB 3
`define IGC_REDIR 4
`define IGC_IOMODE 5
`define IGC_RSTCTL 6
`define IGC_RIEN 7
`define MIC_SEL_LSB 4
`define MIC_SEL_MSB 7
`define CSC_BVD 0
`define CSC_BWARN 1
`define CSC_RDY 2
`define CSC_CD 3
`define SOCK_OE 0
`define SOCK_ATA 1
`define SOCK_LED 2
`define SOCK_RIOUT 3
`define SOCK_LEDON 4
`define IRQ_W 16
`define IRQ_NONE 4'h0
`define IRQ_LED 12
`define IRQ_RING 15
`endif

// *** rtl/pin_sync.v ***
// Three-stage synchroniser with agreement filter for one socket pin
`timescale 1ns/1ps
module pin_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire clk, // System clock
  input wire rst_n, // Synchronised reset, active low
  input wire pin, // Asynchronous pin level
  output reg level_r // Filtered level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Stage chain; level moves only when stages two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      level_r <= RESET_VAL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule // pin_sync

// *** rtl/irq_decode.v ***
// Decoder from a four-bit IRQ select code to a one-hot host IRQ vector
`timescale 1ns/1ps
`include "card_socket_map.vh"
module irq_decode (
  input wire [3:0] sel, // IRQ select code
  input wire req, // Request level to route
  output reg [`IRQ_W-1:0] irq // One-hot IRQ lines
);
  // Valid codes pick IRQ 3,4,5,7,9,10,11,12,14,15; others are dropped
  always @* begin
    irq = {`IRQ_W{1'b0}};
    case (sel)
      4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF: begin
        irq[sel] = req;
      end
      default: begin
        irq = {`IRQ_W{1'b0}};
      end
    endcase
  end
endmodule // irq_decode

// *** tb/card_pins.sv ***
// Card side model: drives the socket status pins off the clock edge
`timescale 1ns/1ps
module card_pins (
  input wire [4:0] want, // Levels {cd_b, cd_a, bwarn, bvd, rdy}
  output wire card_ready_irq_pin, // Ready / interrupt request
  output wire battery_dead_status_pin, // Battery dead / status change
  output wire battery_warning_pin, // Battery warning
  output wire card_detect_a_n, // Card detect one, active low
  output wire card_detect_b_n // Card detect two, active low
);
  wire [4:0] lvl;
  // Pins move 3 ns after a request, so they are asynchronous to clk
  assign #3 lvl = want;
  assign {card_detect_b_n, card_detect_a_n, battery_warning_pin,
    battery_dead_status_pin, card_ready_irq_pin} = lvl;
endmodule // card_pins

// *** tb/card_socket_irq_status_props.sv ***
// Port checker of the socket interrupt and status block
`timescale 1ns/1ps
module card_socket_irq_status_props (
  input wire clk, // Clock
  input wire arst_n, // Reset, active low
  input wire [7:0] addr, // Address
  input wire [7:0] wdata, // Write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  input wire [7:0] rdata_r, // Read data
  input wire [15:0] host_irq_r, // Host IRQ lines
  input wire host_mgmt_interrupt_out_r, // Dedicated output
  input wire card_reset_out_r, // Reset level
  input wire card_reset_oe_r, // Reset enable
  input wire io_mode_r, // I/O mode copy
  input wire ring_indicate_r // Ring level
);
  reg [7:0] igc_r;
  reg [7:0] sock_r;
  reg [2:0] up_r;
  // Mirror of control writes and cycles since reset release
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      igc_r <= 8'h00;
      sock_r <= 8'h00;
      up_r <= 3'h0;
    end else begin
      if (up_r != 3'h5) up_r <= up_r + 3'h1;
      if (wr && addr == 8'h03) igc_r <= wdata;
      if (wr && addr == 8'h08) sock_r <= wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence csc_read; rd && addr == 8'h04; endsequence
  sequence settled; up_r == 3'h5; endsequence
  // Control bits reach the outputs one cycle after the register
  io_mode_a: assert property (
    settled |-> io_mode_r == $past(igc_r[5]))
    else $error("io mode output wrong");
  reset_level_a: assert property (
    settled |-> card_reset_out_r ==
    !($past(igc_r[6]) ^ $past(sock_r[1]))) else $error("reset level wrong");
  reset_float_a: assert property (
    !$past(sock_r[0]) |-> !card_reset_oe_r)
    else $error("reset driven while disabled");
  redirect_a: assert property (
    host_mgmt_interrupt_out_r |-> $past(igc_r[4]))
    else $error("dedicated output without redirect");
  no_reserved_a: assert property (
    (host_irq_r & 16'h2147) == 16'h0000)
    else $error("reserved IRQ line high");
  ring_mem_a: assert property (
    !$past(igc_r[5]) && !$past(igc_r[5], 2) |-> !ring_indicate_r)
    else $error("ring in memory mode");
  csc_upper_a: assert property (
    csc_read |=> rdata_r[7:4] == 4'h0)
    else $error("status upper nibble set");
  ready_io_a: assert property (
    csc_read ##0 (igc_r[5] && $past(igc_r[5])) |=> !rdata_r[2])
    else $error("ready flag in io mode");
  rd_idle_a: assert property (!rd |=> rdata_r == 8'h00)
    else $error("read data outside read cycle");
endmodule // card_socket_irq_status_props
bind card_socket_irq_status card_socket_irq_status_props i_props (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata_r(rdata_r), .host_irq_r(host_irq_r),
  .host_mgmt_interrupt_out_r(host_mgmt_interrupt_out_r),
  .card_reset_out_r(card_reset_out_r), .card_reset_oe_r(card_reset_oe_r),
  .io_mode_r(io_mode_r), .ring_indicate_r(ring_indicate_r));

// *** tb/tb.sv ***
// Self-checking bench of the socket interrupt and status block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [4:0] want = 5'h1F;
  reg [3:0] sel;
  reg [7:0] d;
  reg [4:0] stp [0:5];
  reg [7:0] exf [0:5];
  wire [7:0] rdata_r;
  wire [15:0] host_irq_r;
  wire mgmt, rst_lvl, rst_oe, io_m, ring, rdy_p, bvd_p, bw_p, cda, cdb;
  int errors = 0;
  int checks = 0;
  int i;
  always #5 clk = ~clk;
  card_socket_irq_status i_dut (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
    .card_ready_irq_pin(rdy_p), .battery_dead_status_pin(bvd_p),
    .battery_warning_pin(bw_p), .card_detect_a_n(cda),
    .card_detect_b_n(cdb), .host_irq_r(host_irq_r),
    .host_mgmt_interrupt_out_r(mgmt), .card_reset_out_r(rst_lvl),
    .card_reset_oe_r(rst_oe), .io_mode_r(io_m), .ring_indicate_r(ring));
  card_pins i_pins (.want(want), .card_ready_irq_pin(rdy_p),
    .battery_dead_status_pin(bvd_p), .battery_warning_pin(bw_p),
    .card_detect_a_n(cda), .card_detect_b_n(cdb));
  ////////////////////////////////////////////////////////////////////////////
  // Expected one-hot IRQ vector of a select code
  function automatic [15:0] exp_irq(input [3:0] c);
    case (c)
      4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF:
        exp_irq = 16'h0001 << c;
      default: exp_irq = 16'h0000;
    endcase
  endfunction
  task wr_reg(input [7:0] a, input [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input [7:0] a, input [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata_r, e)
  endtask
  // Change pin levels, then let the synchronisers and flags settle
  task pin(input [4:0] v);
    @(posedge clk);
    want <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task print_verdict;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict;
  end
  initial begin
    {stp[0], stp[1], stp[2]} = {5'h05, 5'h07, 5'h03};
    {stp[3], stp[4], stp[5]} = {5'h07, 5'h06, 5'h07};
    {exf[0], exf[1], exf[2]} = {8'h01, 8'h00, 8'h02};
    {exf[3], exf[4], exf[5]} = {8'h00, 8'h04, 8'h04};
    i = $urandom(32'h8B07);
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h7E, 8'h00);
    d = 8'($urandom);
    wr_reg(8'h03, d);
    rd_chk(8'h03, d);
    wr_reg(8'h03, 8'h00);
    // Insertion to a random management IRQ, then to the dedicated output
    sel = 4'h3 + 4'($urandom % 13);
    if (exp_irq(sel) === 16'h0000) sel = 4'hB;
    wr_reg(8'h05, {sel, 4'h8});
    rd_chk(8'h05, {sel, 4'h8});
    pin(5'h17);
    `CHK(host_irq_r, exp_irq(sel))
    `CHK(mgmt, 1'b0)
    rd_chk(8'h04, 8'h08);
    rd_chk(8'h04, 8'h00);
    #10 `CHK(host_irq_r, 16'h0000)
    wr_reg(8'h03, 8'h10);
    pin(5'h07);
    `CHK(mgmt, 1'b1)
    `CHK(host_irq_r, 16'h0000)
    rd_chk(8'h04, 8'h08);
    // Memory mode edges of battery, warning and ready pins
    for (i = 0; i < 6; i++) begin
      pin(stp[i]);
      rd_chk(8'h04, exf[i]);
    end
    // I/O mode with ring enable: both edges flag, ring follows pin
    wr_reg(8'h03, 8'hA0);
    pin(5'h05);
    `CHK(ring, 1'b1)
    rd_chk(8'h04, 8'h01);
    pin(5'h07);
    rd_chk(8'h04, 8'h01);
    pin(5'h06);
    rd_chk(8'h04, 8'h00);
    // Card request held low, every select code tried
    for (i = 0; i < 16; i++) begin
      wr_reg(8'h03, {4'h2, 4'(i)});
      repeat (3) @(posedge clk);
      `CHK(host_irq_r, exp_irq(4'(i)))
    end
    // Reset level in both polarities, then floated
    for (i = 0; i < 4; i++) begin
      wr_reg(8'h08, {6'h00, i[0], 1'b1});
      wr_reg(8'h03, {1'b0, i[1], 6'h00});
      repeat (2) @(posedge clk);
      `CHK(rst_lvl, !(i[1] ^ i[0]))
      `CHK(rst_oe, 1'b1)
    end
    wr_reg(8'h08, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(rst_oe, 1'b0)
    // Alternate pin uses: LED on IRQ 12, ring indicate on IRQ 15
    wr_reg(8'h08, 8'h14);
    repeat (2) @(posedge clk);
    `CHK(host_irq_r[12], 1'b1)
    wr_reg(8'h03, 8'hA0);
    wr_reg(8'h08, 8'h08);
    pin(5'h04);
    `CHK(host_irq_r[15], 1'b1)
    `CHK(ring, 1'b1)
    `CHK(io_m, 1'b1)
    print_verdict;
  end
endmodule // tb
